// file: verification/rtcc_core_tb_top.sv
// Testbench top: reset, read-out rate, frame errors, writes and password checks
`timescale 1ns/10ps
module rtcc_core_tb_top import rtcc_pkg::*; ();
    localparam int PROG = 20;
    localparam logic [31:0] CFG_NEW = 32'h6003_8010;
    localparam logic [31:0] PWD = 32'h0001_0081;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic por_ok_pin = 1'b0;
    logic rf_clk_pin;
    logic field_on_pin;
    logic load_mod;
    logic cmd_error;
    logic write_done;
    logic pwd_reject;
    logic [31:0] mode_word;
    int n_errors = 0;
    int comparisons = 0;
    int n_wd = 0;
    int n_ce = 0;
    int n_pr = 0;

    always #10 clk = ~clk;

    // Pulses last one cycle, so they are tallied as they pass
    always @(posedge clk) begin
        if (write_done === 1'b1) n_wd <= n_wd + 1;
        if (cmd_error === 1'b1) n_ce <= n_ce + 1;
        if (pwd_reject === 1'b1) n_pr <= n_pr + 1;
    end

    rtcc_core #(.PROG_CYC(PROG), .FIFO_DEPTH(16)) DUT (
        .clk(clk), .rstn(rstn), .rf_clk_pin(rf_clk_pin), .field_on_pin(field_on_pin),
        .por_ok_pin(por_ok_pin), .load_mod(load_mod), .cmd_error(cmd_error),
        .write_done(write_done), .pwd_reject(pwd_reject), .mode_word(mode_word)
    );
    rtcc_reader_model reader (.rf_clk_pin(rf_clk_pin), .field_on_pin(field_on_pin));

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check32

    task automatic check_near(input int got, input int exp, input string what);
        comparisons++;
        if (got < exp - 2 || got > exp + 2) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : check_near

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // Width in clocks of the next high load pulse
    task automatic hi_width(output int w);
        int t;
        t = 0;
        w = 0;
        // Sampled on the falling edge, where the registered output has settled
        while (load_mod !== 1'b1 && t < 4000) begin
            @(negedge clk);
            t++;
        end
        if (t >= 4000) begin
            n_errors++;
            test_done();
        end
        while (load_mod === 1'b1 && w < 4000) begin
            @(negedge clk);
            w++;
        end
    endtask : hi_width

    task automatic frame_wr(input logic [2:0] a, input logic [31:0] d, input logic pw_on,
                            input logic [31:0] pw);
        if (pw_on) reader.send({OP_WRITE, pw, 1'b0, d, a}, 70);
        else reader.send({32'h0, OP_WRITE, 1'b0, d, a}, 38);
        wait_clk(2 * PROG);
    endtask : frame_wr

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_power();
        wait_clk(2);
        rstn <= 1'b1;
        wait_clk(40);
        check32({31'h0, load_mod}, 32'h0, "load idle without supply");
        check32(mode_word, CFG_DEFAULT, "delivered mode");
        por_ok_pin <= 1'b1;
        wait_clk(3);
    endtask : t_power

    task automatic t_rate();
        int w;
        hi_width(w);
        check_near(w, 256, "half bit at carrier/64");
    endtask : t_rate

    task automatic t_bad();
        int b;
        b = n_ce;
        reader.send({65'h0, 5'h15}, 5);
        wait_clk(20);
        check32(32'(n_ce - b), 32'h1, "short frame");
        reader.send({68'h0, 2'h1}, 2);
        wait_clk(20);
        check32(32'(n_ce - b), 32'h2, "bad opcode");
    endtask : t_bad

    task automatic t_store();
        int b;
        b = n_wd;
        frame_wr(BLK_PWD[2:0], PWD, 1'b0, 32'h0);
        check32(32'(n_wd - b), 32'h1, "password block written");
    endtask : t_store

    task automatic t_config();
        int b;
        int w;
        b = n_wd;
        frame_wr(BLK_CFG[2:0], CFG_NEW, 1'b0, 32'h0);
        check32(32'(n_wd - b), 32'h1, "config block written");
        reader.send({68'h0, OP_RESET}, 2);
        hi_width(w);
        check_near(w, 32, "half bit at extended carrier/8");
        check32(mode_word, CFG_NEW, "mode from block 0");
    endtask : t_config

    task automatic t_pwd();
        int bw;
        int bp;
        bw = n_wd;
        bp = n_pr;
        frame_wr(3'h2, 32'h0000_0F00, 1'b1, PWD ^ 32'h1);
        check32(32'(n_pr - bp), 32'h1, "wrong password refused");
        check32(32'(n_wd - bw), 32'h0, "no write on wrong password");
        frame_wr(3'h2, 32'h0000_0F00, 1'b1, PWD);
        check32(32'(n_wd - bw), 32'h1, "write with password");
    endtask : t_pwd

    initial begin
        t_power();
        t_rate();
        t_bad();
        t_store();
        t_config();
        t_pwd();
        test_done();
    end

    // Hang guard
    initial begin
        #1900000;
        n_errors++;
        test_done();
    end
endmodule : rtcc_core_tb_top

// file: verification/rtcc_reader_model.sv
// Reader model: carrier and field-gap keyed command frames
`timescale 1ns/10ps
module rtcc_reader_model (
    // Coil field
    output logic rf_clk_pin,
    output logic field_on_pin
);
    // Carrier stops in gaps, so no tick can be counted there
    initial begin
        rf_clk_pin = 1'b0;
        field_on_pin = 1'b1;
        #33;
        forever begin
            #80;
            rf_clk_pin = field_on_pin ? ~rf_clk_pin : 1'b0;
        end
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge rf_clk_pin);
    endtask : ticks

    // Start gap, one on-interval per bit closed by a gap, then a long on-interval
    task automatic send(input logic [69:0] bits, input int n);
        field_on_pin = 1'b0;
        #1200;
        for (int i = n - 1; i >= 0; i--) begin
            field_on_pin = 1'b1;
            ticks(bits[i] ? 50 : 20);
            field_on_pin = 1'b0;
            // Gap ends between carrier slots, so the field edge never races a toggle
            #1240;
        end
        field_on_pin = 1'b1;
        ticks(73);
    endtask : send
endmodule : rtcc_reader_model

// file: verilog/rtcc_core.sv
// Tag control core: write decoder, memory controller, mode register, bit rate
// ************************************************************
// Overview of operation
// - Outgoing bit rate is carrier divided by any even value from 2 to 128.
// - Legacy mode offers fixed divisors 8,16,32,40,50,64,100,128.
// - Field gaps decode as pulse interval bits; bad frames are discarded.
// - Bit and frame timing counts carrier edges recovered from the field; programming time counts system clocks.
// - Everything stays idle until the power-on indication is good.
// - Mode register loads from block 0 after power-on and while reading.
// - Mode reload at each block read start, power-on and reset command.
// - First two received bits are the opcode: write or reset; a shorter write frame is direct access.
// - In password mode 32 bits after opcode are checked against block 7.
// - Delivered configuration word is 0014_8000, Manchester, carrier/64.
// - Memory is ten 33-bit blocks, accessed as whole blocks only.
// - Block 0 holds configuration, block 7 holds the password.
// - Data goes back by switching a load across the coil.
// - Controller runs memory reads, writes and write error handling.
// ************************************************************
`timescale 1ns/10ps
module rtcc_core import rtcc_pkg::*; #(
    parameter int PROG_CYC = 1000,
    parameter int FIFO_DEPTH = 16
) (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Coil front end
    input wire logic rf_clk_pin,
    input wire logic field_on_pin,
    input wire logic por_ok_pin,
    output logic load_mod,
    // Status
    output logic cmd_error,
    output logic write_done,
    output logic pwd_reject,
    output logic [31:0] mode_word
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] rf_s_q;
    logic [1:0] fld_s_q;
    logic [1:0] por_s_q;
    logic rf_tick;
    logic fld;
    logic por_q;
    logic run_rst;
    logic run_n;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rf_s_q <= '0;
            fld_s_q <= '0;
            por_s_q <= '0;
        end else begin
            rf_s_q <= {rf_s_q[1:0], rf_clk_pin};
            fld_s_q <= {fld_s_q[0], field_on_pin};
            por_s_q <= {por_s_q[0], por_ok_pin};
        end
    end

    assign rf_tick = rf_s_q[1] & ~rf_s_q[2];
    assign fld = fld_s_q[1];
    assign por_q = por_s_q[1];
    // Low supply holds all functional state except the block memory and the pin synchronisers in reset
    assign run_rst = !rstn || !por_q;
    assign run_n = !run_rst;

    // ************************************************************
    // Block memory
    // ************************************************************
    logic [NBLK-1:0][BLKW-1:0] mem_q;
    logic [31:0] mode_q;
    logic pw_mode;
    rtcc_cmd_t fcmd;
    logic pop_w;
    logic pw_ok_w;
    logic wr_ok_w;

    assign pw_mode = mode_q[CFG_PWD];

    // Nonvolatile: survives a supply dip, cleared only by system reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_q <= '0;
            mem_q[BLK_CFG] <= {1'b0, CFG_DEFAULT};
        end else if (wr_ok_w) begin
            mem_q[fcmd.addr] <= {fcmd.lock, fcmd.data};
        end
    end

    // ************************************************************
    // Write decoder
    // ************************************************************
    rtcc_rx_t rx_st_q;
    logic [7:0] pi_cnt_q;
    logic [6:0] nb_q;
    logic [RX_W-1:0] sh_q;
    rtcc_cmd_t cmd_q;
    rtcc_cmd_t cmd_w;
    logic cmd_ok_w;
    logic [1:0] op_w;
    logic end_w;
    logic f_in_ready;
    logic f_in_valid;
    logic rx_busy;

    always_comb begin
        op_w = 2'h1;
        if (nb_q >= LEN_RESET) begin
            op_w = {sh_q[nb_q - 7'h01], sh_q[nb_q - 7'h02]};
        end
    end

    always_comb begin
        cmd_w = '0;
        cmd_ok_w = 1'b0;
        cmd_w.addr = sh_q[F_ADDR_HI:0];
        if (op_w == OP_RESET && nb_q == LEN_RESET) begin
            cmd_ok_w = 1'b1;
            cmd_w.kind = K_RESET;
        end else if (op_w == OP_WRITE) begin
            // Password mode changes the expected frame length
            if (nb_q == (pw_mode ? LEN_WRPW : LEN_WR)) begin
                cmd_ok_w = 1'b1;
                cmd_w.kind = K_WRITE;
                cmd_w.data = sh_q[F_DATA_HI:F_DATA_LO];
                cmd_w.lock = sh_q[F_LOCK];
                cmd_w.pwd = sh_q[F_PWD_HI:F_PWD_LO];
            end else if (nb_q == (pw_mode ? LEN_DAPW : LEN_DA)) begin
                cmd_ok_w = 1'b1;
                cmd_w.kind = K_DIRECT;
                cmd_w.pwd = sh_q[F_DPWD_HI:F_DPWD_LO];
            end
        end
    end

    assign end_w = (rx_st_q == RX_COUNT) && fld && rf_tick && (pi_cnt_q == PI_ONE_MAX);
    assign f_in_valid = (rx_st_q == RX_PUSH);
    assign rx_busy = (rx_st_q != RX_WAIT);

    always_ff @(posedge clk) begin
        if (run_rst) begin
            rx_st_q <= RX_WAIT;
            pi_cnt_q <= '0;
            nb_q <= '0;
            sh_q <= '0;
            cmd_q <= '0;
            cmd_error <= 1'b0;
        end else begin
            cmd_error <= 1'b0;
            case (rx_st_q)
                RX_WAIT: begin
                    if (!fld) begin
                        rx_st_q <= RX_GAP;
                        nb_q <= '0;
                        sh_q <= '0;
                    end
                end
                RX_GAP: begin
                    if (fld) begin
                        rx_st_q <= RX_COUNT;
                        pi_cnt_q <= '0;
                    end
                end
                RX_COUNT: begin
                    if (!fld) begin
                        if (pi_cnt_q < PI_MIN || nb_q == LEN_WRPW) begin
                            cmd_error <= 1'b1;
                            rx_st_q <= RX_WAIT;
                        end else begin
                            sh_q <= {sh_q[RX_W-2:0], pi_cnt_q > PI_ZERO_MAX};
                            nb_q <= nb_q + 7'h01;
                            rx_st_q <= RX_GAP;
                        end
                    end else if (rf_tick) begin
                        if (pi_cnt_q == PI_ONE_MAX) begin
                            if (cmd_ok_w) begin
                                cmd_q <= cmd_w;
                                rx_st_q <= RX_PUSH;
                            end else begin
                                cmd_error <= 1'b1;
                                rx_st_q <= RX_WAIT;
                            end
                        end else begin
                            pi_cnt_q <= pi_cnt_q + 8'h01;
                        end
                    end
                end
                RX_PUSH: begin
                    // Gaps seen while the queue is full are lost
                    if (f_in_ready) begin
                        rx_st_q <= RX_WAIT;
                    end
                end
                default: rx_st_q <= RX_WAIT;
            endcase
        end
    end

    // ************************************************************
    // Command queue
    // ************************************************************
    logic f_out_valid;
    logic [$bits(rtcc_cmd_t)-1:0] f_out_data;
    logic ex_ready;

    rtcc_fifo #(
        .W($bits(rtcc_cmd_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(run_n),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(cmd_q),
        .out_valid(f_out_valid),
        .out_ready(ex_ready),
        .out_data(f_out_data)
    );

    assign fcmd = rtcc_cmd_t'(f_out_data);

    // ************************************************************
    // Memory controller
    // ************************************************************
    logic [15:0] ex_cnt_q;

    assign ex_ready = (ex_cnt_q == '0);
    assign pop_w = f_out_valid && ex_ready;
    assign pw_ok_w = !pw_mode || (fcmd.pwd == mem_q[BLK_PWD][DATW-1:0]);
    assign wr_ok_w = pop_w && fcmd.kind == K_WRITE && pw_ok_w
                     && !mem_q[fcmd.addr][LOCK_BIT];

    always_ff @(posedge clk) begin
        if (run_rst) begin
            ex_cnt_q <= '0;
            write_done <= 1'b0;
            pwd_reject <= 1'b0;
        end else begin
            write_done <= wr_ok_w;
            pwd_reject <= pop_w && fcmd.kind != K_RESET && !pw_ok_w;
            // Programming time stalls the queue, so back-pressure reaches the decoder
            if (wr_ok_w) begin
                ex_cnt_q <= 16'(PROG_CYC);
            end else if (!ex_ready) begin
                ex_cnt_q <= ex_cnt_q - 16'h0001;
            end
        end
    end

    // ************************************************************
    // Data rate and read-out
    // ************************************************************
    rtcc_tx_t tx_st_q;
    logic [7:0] div_q;
    logic [7:0] div_w;
    logic ext_w;
    logic [3:0] blk_q;
    logic [3:0] nxt_blk;
    logic [2:0] maxb;
    logic [31:0] tx_sh_q;
    logic [4:0] bit_q;
    logic [7:0] tx_cnt_q;
    logic manch;

    assign ext_w = (mode_q[CFG_KEY_HI:CFG_KEY_LO] == KEY_EXT_A)
                   || (mode_q[CFG_KEY_HI:CFG_KEY_LO] == KEY_EXT_B);
    assign div_w = ext_w ? ({1'b0, mode_q[CFG_XRATE_HI:CFG_XRATE_LO], 1'b0} + XRATE_BASE)
                         : rtcc_legacy_div(mode_q[CFG_LRATE_HI:CFG_LRATE_LO]);
    assign manch = (mode_q[CFG_MOD_HI:CFG_MOD_LO] == MOD_MANCH);
    assign maxb = mode_q[CFG_MAXB_HI:CFG_MAXB_LO];
    // Zero max block means block 0 is sent forever
    assign nxt_blk = (maxb == 3'h0) ? 4'h0
                   : ((blk_q >= {1'b0, maxb} || blk_q == 4'h0) ? 4'h1 : blk_q + 4'h1);

    always_ff @(posedge clk) begin
        if (run_rst) begin
            div_q <= XRATE_BASE;
        end else begin
            div_q <= div_w;
        end
    end

    assign mode_word = mode_q;

    always_ff @(posedge clk) begin
        if (run_rst) begin
            tx_st_q <= TX_LOAD;
            mode_q <= CFG_DEFAULT;
            blk_q <= '0;
            tx_sh_q <= '0;
            bit_q <= '0;
            tx_cnt_q <= '0;
            load_mod <= 1'b0;
        end else if (pop_w && fcmd.kind == K_RESET) begin
            tx_st_q <= TX_LOAD;
            blk_q <= '0;
            load_mod <= 1'b0;
        end else if (pop_w && fcmd.kind == K_DIRECT && pw_ok_w) begin
            tx_st_q <= TX_LOAD;
            blk_q <= {1'b0, fcmd.addr};
            load_mod <= 1'b0;
        end else begin
            case (tx_st_q)
                TX_OFF: begin
                    load_mod <= 1'b0;
                    if (!rx_busy && ex_ready && !f_out_valid) begin
                        tx_st_q <= TX_LOAD;
                    end
                end
                TX_LOAD: begin
                    mode_q <= mem_q[BLK_CFG][DATW-1:0];
                    tx_sh_q <= mem_q[blk_q][DATW-1:0];
                    bit_q <= '0;
                    tx_cnt_q <= '0;
                    tx_st_q <= TX_BIT;
                end
                TX_BIT: begin
                    if (rx_busy) begin
                        tx_st_q <= TX_OFF;
                        load_mod <= 1'b0;
                    end else if (rf_tick) begin
                        if (tx_cnt_q == 8'h00) begin
                            load_mod <= manch ? ~tx_sh_q[DATW-1] : tx_sh_q[DATW-1];
                        end else if (tx_cnt_q == (div_q >> 1)) begin
                            load_mod <= tx_sh_q[DATW-1];
                        end
                        if (tx_cnt_q == div_q - 8'h01) begin
                            tx_cnt_q <= '0;
                            tx_sh_q <= {tx_sh_q[DATW-2:0], 1'b0};
                            bit_q <= bit_q + 5'h01;
                            if (bit_q == 5'h1F) begin
                                blk_q <= nxt_blk;
                                tx_st_q <= TX_LOAD;
                            end
                        end else begin
                            tx_cnt_q <= tx_cnt_q + 8'h01;
                        end
                    end
                end
                default: tx_st_q <= TX_OFF;
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (run_rst);

    a_div_range: assert property (div_q >= 8'h02 && div_q <= 8'h80)
        else $error("bit divisor out of range");

    a_legacy_rate: assert property (!ext_w && mode_q[CFG_LRATE_HI:CFG_LRATE_LO] == 3'h3
        |=> div_q == 8'h28)
        else $error("legacy code 3 not carrier/40");

    a_ext_rate: assert property (ext_w && mode_q[CFG_XRATE_HI:CFG_XRATE_LO] == 6'h3F
        |=> div_q == 8'h80)
        else $error("extended rate top code not carrier/128");

    a_bad_frame: assert property (end_w && !cmd_ok_w |=> rx_st_q == RX_WAIT && cmd_error
        ##1 !cmd_error)
        else $error("invalid frame not dropped");

    a_por_hold: assert property (@(posedge clk) disable iff (!rstn)
        !por_q |=> !load_mod && !write_done && tx_st_q == TX_LOAD)
        else $error("activity while supply low");

    a_mode_reload: assert property (tx_st_q == TX_LOAD
        |=> mode_q == $past(mem_q[BLK_CFG][DATW-1:0]) && tx_st_q == TX_BIT)
        else $error("mode register not reloaded from block 0");

    a_reset_cmd: assert property (pop_w && fcmd.kind == K_RESET |=> tx_st_q == TX_LOAD
        ##1 mode_q == $past(mem_q[BLK_CFG][DATW-1:0]))
        else $error("reset command did not reload mode");

    a_pwd_reject: assert property (pop_w && fcmd.kind == K_WRITE && !pw_ok_w
        |=> pwd_reject && !write_done && mem_q == $past(mem_q))
        else $error("write with wrong password changed memory");

    a_write_ok: assert property (wr_ok_w |=> write_done
        && mem_q[$past(fcmd.addr)] == $past({fcmd.lock, fcmd.data})
        && ex_cnt_q == 16'(PROG_CYC))
        else $error("accepted write not stored");

    a_mod_tick: assert property (tx_st_q == TX_BIT && $past(tx_st_q) == TX_BIT
        && !$past(rf_tick) && !$past(rx_busy) |-> $stable(load_mod))
        else $error("load changed off a carrier edge");

    c_write: cover property (wr_ok_w ##1 write_done);
    c_reset: cover property (pop_w && fcmd.kind == K_RESET);
    c_reject: cover property (pwd_reject);
    c_full: cover property (f_in_valid && !f_in_ready);

endmodule : rtcc_core

// file: verilog/rtcc_fifo.sv
// Command FIFO between write decoder and memory controller
`timescale 1ns/10ps
module rtcc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] buf_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;

    // Extra pointer bit tells full from empty
    assign in_ready = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
    assign out_valid = (wp_q != rp_q);
    assign out_data = buf_q[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            buf_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp_q <= '0;
        end else if (in_valid && in_ready) begin
            wp_q <= wp_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rp_q <= '0;
        end else if (out_valid && out_ready) begin
            rp_q <= rp_q + 1'b1;
        end
    end

endmodule : rtcc_fifo

// file: verilog/rtcc_pkg.sv
// Shared constants, field layouts and types of the tag control core
package rtcc_pkg;

    // ************************************************************
    // Memory organisation
    // ************************************************************
    localparam int NBLK = 10;
    localparam int BLKW = 33;
    localparam int DATW = 32;
    localparam int LOCK_BIT = 32;
    localparam logic [3:0] BLK_CFG = 4'h0;
    localparam logic [3:0] BLK_PWD = 4'h7;
    localparam logic [31:0] CFG_DEFAULT = 32'h0014_8000;

    // ************************************************************
    // Configuration word fields
    // ************************************************************
    localparam int CFG_KEY_HI = 31;
    localparam int CFG_KEY_LO = 28;
    localparam logic [3:0] KEY_EXT_A = 4'h6;
    localparam logic [3:0] KEY_EXT_B = 4'h9;
    localparam int CFG_XRATE_HI = 21;
    localparam int CFG_XRATE_LO = 16;
    localparam int CFG_LRATE_HI = 20;
    localparam int CFG_LRATE_LO = 18;
    localparam int CFG_MOD_HI = 15;
    localparam int CFG_MOD_LO = 11;
    localparam logic [4:0] MOD_MANCH = 5'h10;
    localparam int CFG_MAXB_HI = 7;
    localparam int CFG_MAXB_LO = 5;
    localparam int CFG_PWD = 4;
    localparam logic [7:0] XRATE_BASE = 8'h02;

    // ************************************************************
    // Write stream framing, intervals in carrier periods
    // ************************************************************
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam int RX_W = 70;
    localparam logic [6:0] LEN_RESET = 7'h02;
    localparam logic [6:0] LEN_DA = 7'h06;
    localparam logic [6:0] LEN_WR = 7'h26;
    localparam logic [6:0] LEN_DAPW = 7'h26;
    localparam logic [6:0] LEN_WRPW = 7'h46;
    localparam logic [7:0] PI_MIN = 8'h0C;
    localparam logic [7:0] PI_ZERO_MAX = 8'h24;
    localparam logic [7:0] PI_ONE_MAX = 8'h48;
    localparam int F_ADDR_HI = 2;
    localparam int F_DATA_LO = 3;
    localparam int F_DATA_HI = 34;
    localparam int F_LOCK = 35;
    localparam int F_PWD_LO = 36;
    localparam int F_PWD_HI = 67;
    localparam int F_DPWD_LO = 4;
    localparam int F_DPWD_HI = 35;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {K_RESET = 2'b00, K_WRITE = 2'b01, K_DIRECT = 2'b10} rtcc_kind_t;
    typedef enum logic [1:0] {RX_WAIT = 2'b00, RX_GAP = 2'b01, RX_COUNT = 2'b10,
                              RX_PUSH = 2'b11} rtcc_rx_t;
    typedef enum logic [1:0] {TX_OFF = 2'b00, TX_LOAD = 2'b01, TX_BIT = 2'b10} rtcc_tx_t;

    typedef struct packed {
        rtcc_kind_t kind;
        logic [31:0] pwd;
        logic lock;
        logic [31:0] data;
        logic [2:0] addr;
    } rtcc_cmd_t;

    function automatic logic [7:0] rtcc_legacy_div(input logic [2:0] code);
        case (code)
            3'h0: rtcc_legacy_div = 8'h08;
            3'h1: rtcc_legacy_div = 8'h10;
            3'h2: rtcc_legacy_div = 8'h20;
            3'h3: rtcc_legacy_div = 8'h28;
            3'h4: rtcc_legacy_div = 8'h32;
            3'h5: rtcc_legacy_div = 8'h40;
            3'h6: rtcc_legacy_div = 8'h64;
            default: rtcc_legacy_div = 8'h80;
        endcase
    endfunction : rtcc_legacy_div

endpackage : rtcc_pkg
